//--- design/tdc_control_regs.sv
// register logic, start control and flags of a single and triple des unit
// How it works
// R1: start bit one launches manual run
// R2: soft reset bit resets whole unit; memData1 and memData2 keep their values
// R3: bit 0 direction, bit 1 triple des
// R4: triple bit set uses three keys, or two with bit 4 set
// R5: bit 4 picks three or two keys
// R6: start field manual, auto, dma; memory results
// R7: dma with last output keeps result local
// R8: chaining field ecb, cbc, ofb, cfb
// R9: output read clears ready, last output off
// R10: input write clears ready, last output on
// R11: no output reads mid dma run
// R12: feedback size 64, 32, 16, 8 bits
// R13: enable register ones set enables
// R14: disable register ones clear enables
// R15: start or soft reset clears ready
// R16: only soft reset clears bad access
// R17: mode write while busy flags bad access
// R18: enabled flag drives interrupt line
// R19: auto mode starts after both inputs
`timescale 1ns/1ps
`include "tdc_defines.svh"

module tdc_control_regs (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  input wire logic coreDone,
  input wire logic [31:0] coreOut1,
  input wire logic [31:0] coreOut2,
  input wire logic dmaRxEnd,
  input wire logic dmaTxEnd,
  input wire logic dmaRxFull,
  input wire logic dmaTxEmpty,
  output logic coreStart,
  output logic coreReset,
  output logic [31:0] coreIn1,
  output logic [31:0] coreIn2,
  output logic encrypt,
  output logic tripleDes,
  output logic twoKey,
  output tdc_pkg::tdc_start_t startMode,
  output tdc_pkg::tdc_chain_t chainMode,
  output tdc_pkg::tdc_feedback_size_field_t feedbackSize,
  output logic lastOutput,
  output logic memWrite,
  output logic [31:0] memData1,
  output logic [31:0] memData2,
  output logic irq
);
  import tdc_pkg::*;

  // ************************************************
  // declarations
  // ************************************************
  logic [31:0] modeQ, out1Q, out2Q, in1Q, in2Q, memData1Q, memData2Q, rdDataQ, rdDataD;
  logic [1:0] inSeenQ;
  logic readyQ, badQ, startQ, softRstQ, memWriteQ, irqQ;
  tdc_bad_t badTypeQ;
  tdc_state_t stateQ;
  logic [`TDC_NUM_SRC-1:0] maskQ, statusVec, irqBits;
  logic wrCtrl, wrMode, wrIrqSet, wrIrqClr, wrIn1, wrIn2, wrIn, rdOut, rdWriteOnly;
  logic softRst, cmdStart, autoStart, launch, busy, isDma;
  tdc_start_t modeStart;

  // ************************************************
  // address decode
  // ************************************************
  assign wrCtrl = wrStb && (addr == `TDC_OFS_CONTROL);
  assign wrMode = wrStb && (addr == `TDC_OFS_MODE);
  assign wrIrqSet = wrStb && (addr == `TDC_OFS_IRQ_SET);
  assign wrIrqClr = wrStb && (addr == `TDC_OFS_IRQ_CLR);
  assign wrIn1 = wrStb && (addr == `TDC_OFS_IN1);
  assign wrIn2 = wrStb && (addr == `TDC_OFS_IN2);
  assign wrIn = wrIn1 || wrIn2;
  assign rdOut = rdStb && ((addr == `TDC_OFS_OUT1) || (addr == `TDC_OFS_OUT2));
  // reading a key, input, vector or command word betrays nothing, it only flags
  assign rdWriteOnly = rdStb && ((addr == `TDC_OFS_CONTROL) || (addr == `TDC_OFS_IRQ_SET) ||
    (addr == `TDC_OFS_IRQ_CLR) || (addr == `TDC_OFS_IN1) || (addr == `TDC_OFS_IN2) ||
    (addr == `TDC_OFS_IV1) || (addr == `TDC_OFS_IV2) ||
    ((addr >= `TDC_OFS_KEY_LO) && (addr <= `TDC_OFS_KEY_HI) && (addr[1:0] == 2'h0)));

  // R2: soft reset command
  assign softRst = wrCtrl && wrData[`TDC_CR_SOFTRST];
  // R1: start command, zero is ignored
  assign cmdStart = wrCtrl && wrData[`TDC_CR_START] && !softRst;

  assign modeStart = tdc_start_t'(modeQ[`TDC_MR_START_LO +: 2]);
  assign isDma = (modeStart == TDC_START_DMA);
  assign busy = (stateQ == TDC_BUSY);

  // R19: auto and dma runs fire once both input words are in
  assign autoStart = (modeStart == TDC_START_AUTO || isDma) && !softRst &&
    ((inSeenQ[0] || wrIn1) && (inSeenQ[1] || wrIn2)) && wrIn;
  // R1 R19: manual or automatic launch while idle
  assign launch = (cmdStart && !busy) || (autoStart && !busy);

  // ************************************************
  // processing state
  // ************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      stateQ <= TDC_IDLE;
    else if (softRst)
      stateQ <= TDC_IDLE;
    else
      unique case (stateQ)
        TDC_IDLE:
          if (launch)
            stateQ <= TDC_BUSY;
        TDC_BUSY:
          if (coreDone)
            stateQ <= TDC_IDLE;
      endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      startQ <= 1'b0;
    else
      startQ <= launch;
  end

  // R2: one cycle reset toward the cipher core
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      softRstQ <= 1'b0;
    else
      softRstQ <= softRst;
  end

  // ************************************************
  // mode register and input words
  // ************************************************
  // R17: mode is frozen during a run, the write only flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      modeQ <= `TDC_MR_RESET;
    else if (softRst)
      modeQ <= `TDC_MR_RESET;
    else if (wrMode && !busy)
      modeQ <= wrData & `TDC_MR_WMASK;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in1Q <= 32'h0;
      in2Q <= 32'h0;
    end
    else if (softRst)
    begin
      in1Q <= 32'h0;
      in2Q <= 32'h0;
    end
    else
    begin
      if (wrIn1)
        in1Q <= wrData;
      if (wrIn2)
        in2Q <= wrData;
    end
  end

  // R19: remember which input words arrived
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      inSeenQ <= 2'h0;
    else if (softRst || launch)
      inSeenQ <= 2'h0;
    else
    begin
      if (wrIn1)
        inSeenQ[0] <= 1'b1;
      if (wrIn2)
        inSeenQ[1] <= 1'b1;
    end
  end

  // ************************************************
  // results
  // ************************************************
  // R6: dma run without last output hands result to memory
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memWriteQ <= 1'b0;
      memData1Q <= 32'h0;
      memData2Q <= 32'h0;
    end
    else
    begin
      memWriteQ <= busy && coreDone && isDma && !modeQ[`TDC_MR_LOD] && !softRst;
      if (busy && coreDone && isDma && !modeQ[`TDC_MR_LOD])
      begin
        memData1Q <= coreOut1;
        memData2Q <= coreOut2;
      end
    end
  end

  // R7: otherwise the output words hold the result
  // R11: mid dma run these words may be stale, no guard here
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out1Q <= 32'h0;
      out2Q <= 32'h0;
    end
    else if (softRst)
    begin
      out1Q <= 32'h0;
      out2Q <= 32'h0;
    end
    else if (busy && coreDone && !(isDma && !modeQ[`TDC_MR_LOD]))
    begin
      out1Q <= coreOut1;
      out2Q <= coreOut2;
    end
  end

  // ************************************************
  // status flags and interrupt enables
  // ************************************************
  // completion wins over every clear except soft reset in the same cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      readyQ <= 1'b0;
    // R15: soft reset clears ready
    else if (softRst)
      readyQ <= 1'b0;
    else if (busy && coreDone && !(isDma && !modeQ[`TDC_MR_LOD]))
      readyQ <= 1'b1;
    // R15: start command clears ready
    else if (cmdStart)
      readyQ <= 1'b0;
    // R9: output read clears ready
    else if (!modeQ[`TDC_MR_LOD] && !isDma && rdOut)
      readyQ <= 1'b0;
    // R10: input write clears ready
    else if (modeQ[`TDC_MR_LOD] && wrIn)
      readyQ <= 1'b0;
  end

  // R16: sticky until soft reset only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      badQ <= 1'b0;
      badTypeQ <= TDC_BAD_IN_WR_DMA;
    end
    else if (softRst)
    begin
      badQ <= 1'b0;
      badTypeQ <= TDC_BAD_IN_WR_DMA;
    end
    // R17: mode write during a run
    else if (wrMode && busy)
    begin
      badQ <= 1'b1;
      badTypeQ <= TDC_BAD_MODE_WR;
    end
    else if (wrIn && busy && isDma)
    begin
      badQ <= 1'b1;
      badTypeQ <= TDC_BAD_IN_WR_DMA;
    end
    else if (rdOut && busy)
    begin
      badQ <= 1'b1;
      badTypeQ <= TDC_BAD_OUT_RD;
    end
    else if (rdWriteOnly)
    begin
      badQ <= 1'b1;
      badTypeQ <= TDC_BAD_WO_RD;
    end
  end

  assign statusVec = {badQ, dmaTxEmpty, dmaRxFull, dmaTxEnd, dmaRxEnd, readyQ};
  assign irqBits = {wrData[`TDC_IRQ_BAD], wrData[`TDC_IRQ_TXEMPTY:`TDC_IRQ_RDY]};

  // R13: enable and disable writes
  tdc_irq_mask uMask (
    .clock(clock),
    .rst_n(rst_n),
    .softReset(softRst),
    .setStb(wrIrqSet),
    .clrStb(wrIrqClr),
    .wrBits(irqBits),
    .status(statusVec),
    .maskQ(maskQ),
    .irqQ(irqQ)
  );

  // ************************************************
  // read data, valid the cycle after the strobe only
  // ************************************************
  always_comb
  begin
    rdDataD = 32'h0;
    if (rdStb)
    begin
      unique case (addr)
        `TDC_OFS_MODE:
          rdDataD = modeQ;
        `TDC_OFS_IRQ_MASK:
          rdDataD = {27'h0, maskQ[4:0]} | ({31'h0, maskQ[5]} << `TDC_IRQ_BAD);
        `TDC_OFS_STATUS:
          rdDataD = {27'h0, statusVec[4:0]} | ({31'h0, statusVec[5]} << `TDC_IRQ_BAD) |
            ({30'h0, badTypeQ} << `TDC_ST_TYPE_LO);
        `TDC_OFS_OUT1:
          rdDataD = out1Q;
        `TDC_OFS_OUT2:
          rdDataD = out2Q;
        // write-only and unmapped words read as zero
        default:
          rdDataD = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdDataQ <= 32'h0;
    else
      rdDataQ <= rdDataD;
  end

  // ************************************************
  // outputs
  // ************************************************
  assign rdData = rdDataQ;
  assign coreStart = startQ;
  assign coreReset = softRstQ;
  assign coreIn1 = in1Q;
  assign coreIn2 = in2Q;
  // R3 R4 R5: direction and key bits
  assign encrypt = modeQ[`TDC_MR_CIPHER];
  assign tripleDes = modeQ[`TDC_MR_TRIPLE];
  assign twoKey = modeQ[`TDC_MR_KEYSCHEME];
  // R6 R8 R12: start, chaining, feedback fields
  assign startMode = modeStart;
  assign chainMode = tdc_chain_t'(modeQ[`TDC_MR_CHAIN_LO +: 2]);
  assign feedbackSize = tdc_feedback_size_field_t'(modeQ[`TDC_MR_FEEDBACK_SIZE_FIELD_LO +: 2]);
  assign lastOutput = modeQ[`TDC_MR_LOD];
  assign memWrite = memWriteQ;
  assign memData1 = memData1Q;
  assign memData2 = memData2Q;
  // R18: interrupt line
  assign irq = irqQ;
endmodule // tdc_control_regs

//--- inc/tdc_defines.svh
// register offsets, field positions and reset values of the des control block
`ifndef TDC_DEFINES_SVH
`define TDC_DEFINES_SVH

// ************************************************
// register byte offsets
// ************************************************
`define TDC_OFS_CONTROL 8'h00
`define TDC_OFS_MODE 8'h04
`define TDC_OFS_IRQ_SET 8'h10
`define TDC_OFS_IRQ_CLR 8'h14
`define TDC_OFS_IRQ_MASK 8'h18
`define TDC_OFS_STATUS 8'h1c
`define TDC_OFS_KEY_LO 8'h20
`define TDC_OFS_KEY_HI 8'h34
`define TDC_OFS_IN1 8'h40
`define TDC_OFS_IN2 8'h44
`define TDC_OFS_OUT1 8'h50
`define TDC_OFS_OUT2 8'h54
`define TDC_OFS_IV1 8'h60
`define TDC_OFS_IV2 8'h64

// ************************************************
// control fields
// ************************************************
`define TDC_CR_START 0
`define TDC_CR_SOFTRST 8

// ************************************************
// mode fields
// ************************************************
`define TDC_MR_CIPHER 0
`define TDC_MR_TRIPLE 1
`define TDC_MR_KEYSCHEME 4
`define TDC_MR_START_LO 8
`define TDC_MR_CHAIN_LO 12
`define TDC_MR_LOD 15
`define TDC_MR_FEEDBACK_SIZE_FIELD_LO 16
`define TDC_MR_RESET 32'h0000_0002
`define TDC_MR_WMASK 32'h0003_b313

// ************************************************
// interrupt and status fields
// ************************************************
`define TDC_IRQ_RDY 0
`define TDC_IRQ_RXEND 1
`define TDC_IRQ_TXEND 2
`define TDC_IRQ_RXFULL 3
`define TDC_IRQ_TXEMPTY 4
`define TDC_IRQ_BAD 8
`define TDC_ST_TYPE_LO 12
`define TDC_NUM_SRC 6

`endif

//--- inc/tdc_pkg.sv
// types of the des control block
package tdc_pkg;
  typedef enum logic [1:0] {
    TDC_START_MANUAL = 2'h0,
    TDC_START_AUTO = 2'h1,
    TDC_START_DMA = 2'h2,
    TDC_START_RSVD = 2'h3
  } tdc_start_t;

  typedef enum logic [1:0] {
    TDC_CHAIN_ECB = 2'h0,
    TDC_CHAIN_CBC = 2'h1,
    TDC_CHAIN_OFB = 2'h2,
    TDC_CHAIN_CFB = 2'h3
  } tdc_chain_t;

  typedef enum logic [1:0] {
    TDC_CFB_64 = 2'h0,
    TDC_CFB_32 = 2'h1,
    TDC_CFB_16 = 2'h2,
    TDC_CFB_8 = 2'h3
  } tdc_feedback_size_field_t;

  typedef enum logic [1:0] {
    TDC_BAD_IN_WR_DMA = 2'h0,
    TDC_BAD_OUT_RD = 2'h1,
    TDC_BAD_MODE_WR = 2'h2,
    TDC_BAD_WO_RD = 2'h3
  } tdc_bad_t;

  typedef enum logic {
    TDC_IDLE = 1'b0,
    TDC_BUSY = 1'b1
  } tdc_state_t;
endpackage

//--- design/tdc_irq_mask.sv
// interrupt enable bits and the interrupt line of the des control block
`timescale 1ns/1ps
`include "tdc_defines.svh"

module tdc_irq_mask (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic setStb,
  input wire logic clrStb,
  input wire logic [`TDC_NUM_SRC-1:0] wrBits,
  input wire logic [`TDC_NUM_SRC-1:0] status,
  output logic [`TDC_NUM_SRC-1:0] maskQ,
  output logic irqQ
);
  import tdc_pkg::*;

  // ************************************************
  // per source enable bit
  // ************************************************
  genvar i;
  generate
    for (i = 0; i < `TDC_NUM_SRC; i++)
    begin : gSrc
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          maskQ[i] <= 1'b0;
        else if (softReset)
          maskQ[i] <= 1'b0;
        // R13: set on one
        else if (setStb && wrBits[i])
          maskQ[i] <= 1'b1;
        // R14: clear on one
        else if (clrStb && wrBits[i])
          maskQ[i] <= 1'b0;
      end
    end
  endgenerate

  // ************************************************
  // interrupt line
  // ************************************************
  // R18: enabled flag raises line
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irqQ <= 1'b0;
    else
      irqQ <= |(status & maskQ);
  end
endmodule // tdc_irq_mask

//--- test/tdc_control_regs_monitor.sv
// assertion checker for the des control registers
`timescale 1ns/1ps
module tdc_control_regs_monitor (
  input logic clock,
  input logic rst_n,
  input logic [7:0] addr,
  input logic [31:0] wrData,
  input logic wrStb,
  input logic rdStb,
  input logic [31:0] rdData,
  input logic coreStart,
  input logic coreReset,
  input logic encrypt,
  input logic tripleDes,
  input logic twoKey,
  input tdc_pkg::tdc_start_t startMode,
  input logic lastOutput,
  input logic memWrite,
  input logic irq
);
  import tdc_pkg::*;
  logic ctlWr;
  logic cause;
  logic [5:0] modeBits;
  logic [5:0] wrMode;
  assign ctlWr = wrStb && addr == 8'h00;
  assign cause = ctlWr && wrData[0] || wrStb && (addr == 8'h40 || addr == 8'h44);
  assign modeBits = {startMode, lastOutput, twoKey, tripleDes, encrypt};
  assign wrMode = {wrData[9:8], wrData[15], wrData[4], wrData[1:0]};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // *****
  // checks
  // *****
  a_start_cause: assert property (coreStart |-> $past(cause))
    else $error("start pulse without a cause");
  a_start_single: assert property (coreStart |=> !coreStart)
    else $error("start pulse longer than one cycle");
  a_softrst_pulse: assert property (ctlWr && wrData[8] |-> ##[1:2] coreReset)
    else $error("soft reset not passed on");
  a_softrst_mode: assert property (ctlWr && wrData[8] |=> ##1 modeBits == 6'h02)
    else $error("mode not back to reset value");
  a_mode_write: assert property (wrStb && addr == 8'h04 |=> modeBits == $past(wrMode) || $stable(modeBits))
    else $error("mode fields differ from written value");
  a_mode_hold: assert property (!(wrStb && (addr == 8'h00 || addr == 8'h04)) && !$past(ctlWr) |=> $stable(modeBits))
    else $error("mode changed without a write");
  a_mem_mode: assert property (memWrite |-> startMode == TDC_START_DMA && !lastOutput)
    else $error("memory write outside dma mode");
  a_irq_clear: assert property (wrStb && addr == 8'h14 && wrData[8:0] == 9'h11f |=> ##1 !irq)
    else $error("interrupt stays after disable");
  a_wo_read: assert property (rdStb && (addr == 8'h00 || addr == 8'h10 || addr == 8'h40) |=> rdData == 32'h0)
    else $error("write-only word reads nonzero");
  a_rd_idle: assert property (!rdStb |=> rdData == 32'h0)
    else $error("read data outside read cycle");
endmodule // tdc_control_regs_monitor

bind tdc_control_regs tdc_control_regs_monitor i_tdc_control_regs_monitor (.clock, .rst_n, .addr, .wrData, .wrStb,
  .rdStb, .rdData, .coreStart, .coreReset, .encrypt, .tripleDes, .twoKey, .startMode, .lastOutput, .memWrite, .irq);

//--- test/tdc_core_model.sv
// cipher core stand-in for the des control registers
`timescale 1ns/1ps
module tdc_core_model (
  input logic clock,
  input logic rst_n,
  input logic coreStart,
  input logic coreReset,
  input logic [31:0] coreIn1,
  input logic [31:0] coreIn2,
  input logic encrypt,
  input logic [7:0] latency,
  output logic coreDone,
  output logic [31:0] coreOut1,
  output logic [31:0] coreOut2
);
  logic [7:0] cnt_q;
  logic [31:0] res1_q;
  logic [31:0] res2_q;
  // results shown only in the done cycle; inverted otherwise so stale data is caught
  assign coreOut1 = coreDone ? res1_q : ~res1_q;
  assign coreOut2 = coreDone ? res2_q : ~res2_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 8'h00;
      coreDone <= 1'b0;
    end
    else if (coreReset)
    begin
      cnt_q <= 8'h00;
      coreDone <= 1'b0;
    end
    else
    begin
      coreDone <= cnt_q == 8'h01;
      if (coreStart)
      begin
        cnt_q <= latency;
        res1_q <= coreIn1 ^ (encrypt ? 32'hffff_0000 : 32'h0000_ffff);
        res2_q <= coreIn2 ^ (encrypt ? 32'hffff_0000 : 32'h0000_ffff);
      end
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // tdc_core_model

//--- test/tdc_control_regs_tb.sv
// self-checking bench for the des control registers
`timescale 1ns/1ps
module tdc_control_regs_tb;
  import tdc_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [3:0] dma = 4'h5;
  logic [7:0] latency = 8'h04;
  logic [31:0] rdData, coreIn1, coreIn2, coreOut1, coreOut2, memData1, memData2, memSeen;
  logic coreDone, coreStart, coreReset, encrypt, tripleDes, twoKey, lastOutput, memWrite, irq;
  tdc_start_t startMode;
  tdc_chain_t chainMode;
  tdc_feedback_size_field_t feedbackSize;
  int num_errors = 0;
  int num_checks = 0;
  int memCount = 0;
  // written mode word beside its read back
  logic [31:0] rows [5][2] = '{'{32'h0, 32'h0}, '{32'h0001_1113, 32'h0001_1113}, '{32'h0002_2200, 32'h0002_2200},
    '{32'h0003_b300, 32'h0003_b300}, '{32'hffff_ffff, 32'h0003_b313}};

  always #5 clock = ~clock;
  always @(posedge clock)
    if (memWrite === 1'b1)
    begin
      memCount <= memCount + 1;
      memSeen <= memData1;
    end

  tdc_control_regs i_tdc_control_regs (.clock, .rst_n, .addr, .wrData, .wrStb, .rdStb, .rdData, .coreDone, .coreOut1,
    .coreOut2, .dmaRxEnd(dma[0]), .dmaTxEnd(dma[1]), .dmaRxFull(dma[2]), .dmaTxEmpty(dma[3]), .coreStart, .coreReset,
    .coreIn1, .coreIn2, .encrypt, .tripleDes, .twoKey, .startMode, .chainMode, .feedbackSize, .lastOutput, .memWrite,
    .memData1, .memData2, .irq);
  tdc_core_model i_tdc_core_model (.clock, .rst_n, .coreStart, .coreReset, .coreIn1, .coreIn2, .encrypt, .latency,
    .coreDone, .coreOut1, .coreOut2);

  // *****
  // tasks
  // *****
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1 check(rdData, exp);
  endtask
  task wait_done();
    int n;
    for (n = 0; n < 300 && coreDone !== 1'b1; n++)
      @(posedge clock) #1;
    if (n == 300)
    begin
      check(1'b0, 1'b1);
      close_out();
    end
    repeat (2) @(posedge clock);
    #1;
  endtask
  task run(input logic [31:0] d1, input logic [31:0] d2, input logic manual);
    wr(8'h40, d1);
    wr(8'h44, d2);
    if (manual)
      wr(8'h00, 32'h1);
    wait_done();
  endtask
  function automatic logic [31:0] stat(input logic bad, input logic [1:0] typ, input logic rdy);
    return {18'h0, typ, 3'h0, bad, 3'h0, dma, rdy};
  endfunction
  function automatic logic [31:0] res(input logic [31:0] d, input logic enc);
    return d ^ (enc ? 32'hffff_0000 : 32'h0000_ffff);
  endfunction

  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rdc(8'h04, 32'h2);
    check(tripleDes, 1'b1);
    rdc(8'h18, 32'h0);
    rdc(8'h1c, stat(0, 0, 0));
    rdc(8'h08, 32'h0);
    @(posedge clock) dma <= 4'h0;
    foreach (rows[i])
    begin
      wr(8'h04, rows[i][0]);
      rdc(8'h04, rows[i][1]);
      check({feedbackSize, chainMode, startMode, lastOutput, twoKey, tripleDes, encrypt}, {rows[i][1][17:16],
        rows[i][1][13:12], rows[i][1][9:8], rows[i][1][15], rows[i][1][4], rows[i][1][1:0]});
    end
    wr(8'h04, 32'h1);
    wr(8'h10, 32'h1);
    run(32'h1234_5678, 32'h9abc_def0, 1'b1);
    check(irq, 1'b1);
    rdc(8'h54, res(32'h9abc_def0, 1));
    rdc(8'h1c, stat(0, 0, 0));
    run(32'h0bad_f00d, 32'h0, 1'b1);
    latency <= 8'h14;
    wr(8'h00, 32'h1);
    rdc(8'h1c, stat(0, 0, 0));
    wr(8'h04, 32'h0);
    rdc(8'h1c, stat(1, 2, 0));
    rdc(8'h04, 32'h1);
    wait_done();
    rdc(8'h10, 32'h0);
    rdc(8'h50, res(32'h0bad_f00d, 1));
    rdc(8'h1c, stat(1, 3, 0));
    wr(8'h00, 32'h100);
    rdc(8'h1c, stat(0, 0, 0));
    rdc(8'h04, 32'h2);
    rdc(8'h18, 32'h0);
    // auto start, ready kept after output read until next input write
    latency <= 8'h04;
    wr(8'h04, 32'h8101);
    run(32'h5555_aaaa, 32'h1, 1'b0);
    rdc(8'h50, res(32'h5555_aaaa, 1));
    rdc(8'h1c, stat(0, 0, 1));
    wr(8'h40, 32'h0);
    rdc(8'h1c, stat(0, 0, 0));
    // dma runs: no output reads before the result is in
    wr(8'h04, 32'h0200);
    run(32'hcafe_0000, 32'h2, 1'b0);
    check(memCount, 1);
    check(memSeen, res(32'hcafe_0000, 0));
    check(memData2, res(32'h2, 0));
    rdc(8'h1c, stat(0, 0, 0));
    wr(8'h04, 32'h8201);
    run(32'h0000_beef, 32'h3, 1'b0);
    check(memCount, 1);
    rdc(8'h1c, stat(0, 0, 1));
    rdc(8'h50, res(32'h0000_beef, 1));
    @(posedge clock) dma <= 4'hf;
    wr(8'h10, 32'h11f);
    rdc(8'h18, 32'h11f);
    check(irq, 1'b1);
    wr(8'h14, 32'h01e);
    rdc(8'h18, 32'h101);
    wr(8'h14, 32'h11f);
    rdc(8'h18, 32'h0);
    check(irq, 1'b0);
    // hardware reset while idle, ready set and one source enabled
    wr(8'h10, 32'h1);
    @(posedge clock) #1 check(irq, 1'b1);
    @(posedge clock) rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rdc(8'h04, 32'h2);
    rdc(8'h18, 32'h0);
    rdc(8'h1c, stat(0, 0, 0));
    check(irq, 1'b0);
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    $display("FAIL %0t run timed out", $time);
    close_out();
  end
endmodule // tdc_control_regs_tb
